// ---- core/flash_prot_consts.svh ----
// Offsets, field positions and reset values of the write-protection block.
// Assumes inclusion by the block's module, the host model and the bench only.
// Contract
// [R1] The protected legacy region comes from status1 bits 4..2 and config1 bit 5.
// [R2] Codes 000..111 pick none, 1/64, 1/32, 1/16, 1/8, 1/4, 1/2, all; select 0 top, 1 bottom.
// [R3] Config1 bit 4 locks the registers for good, config1 bit 0 locks them until reset.
// [R4] The temporary lock holds until power down, hardware reset or chip-select reset.
// [R5] Permanent lock set freezes region, top/bottom and small-sector bits whatever bit 0 says.
// [R6] With both lock bits clear the status and configuration registers write normally.
// [R7] While configuration is locked the chosen legacy region stays protected.
// [R8] The host reads and writes these bits with register transactions, write enable first.
// [R9] Each sector can be protected on its own by a volatile and a nonvolatile bit.
// [R10] A sector bit of 0 protects the sector and a 1 leaves it open, for both bits.
// [R11] Volatile bits change freely; nonvolatile bits are programmed to 0 or erased as a group.
// [R12] Persistent mode refuses writes to config1 6,5,4,2, config3 3, options and password.
// [R13] A volatile bit governs only a sector whose nonvolatile bit is 1; else it stays protected.
// [R14] Program or erase to a protected sector is refused and the array left unchanged.
`ifndef FLASH_PROT_CONSTS_SVH
`define FLASH_PROT_CONSTS_SVH
// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define REG_STATUS1 8'h00
`define REG_CONFIG1 8'h04
`define REG_CONFIG3 8'h08
`define REG_SECT_OPT 8'h0C
`define REG_PWD_LO 8'h10
`define REG_PWD_HI 8'h14
`define REG_WREN_CMD 8'h18
`define REG_SECT_SEL 8'h1C
`define REG_SECT_BITS 8'h20
`define REG_ARRAY_OP 8'h24
`define REG_ARRAY_STAT 8'h28
// ----------------------------------------
// Field positions
// ----------------------------------------
`define ST1_REGION_HI 4
`define ST1_REGION_LO 2
`define ST1_WEL 1
`define CF1_SPLIT 6
`define CF1_TOPBOT 5
`define CF1_PERM 4
`define CF1_SMALL_TB 2
`define CF1_TEMP 0
`define CF3_UNIHYB 3
`define OPT_PERSIST 1
`define SB_VOL 0
`define SB_NV 1
`define SB_PROT 2
`define SB_ERASE_ALL 8
`define OP_ERASE 16
`define AST_GRANT 0
`define AST_REFUSED 1
// ----------------------------------------
// Reset values and region coding
// ----------------------------------------
`define SECT_OPT_RESET 16'hFFFF
`define PWD_RESET 64'hFFFF_FFFF_FFFF_FFFF
`define REGION_NONE 3'h0
`define REGION_ALL 3'h7
`define SECTOR_GRAIN 64
`endif

// ---- core/flash_prot_pkg.sv ----
// Types shared by the write-protection block and its bench.
// Assumes a 32-bit classic Wishbone bus with byte addresses.
package flash_prot_pkg;
    // ----------------------------------------
    // Bus carriers
    // ----------------------------------------
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wbReq_t;
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } wbRsp_t;
    // ----------------------------------------
    // Granted array operation
    // ----------------------------------------
    typedef struct packed {
        logic valid;
        logic erase;
        logic [15:0] sector;
    } arrayOp_t;
endpackage

// ---- core/flash_write_protection_logic.sv ----
// Legacy region and per-sector write protection behind a Wishbone slave.
// Assumes one clock, a reset controller pulsing deviceResetEvent on
// hardware or chip-select reset, and an array engine acting on arrayOp.
`timescale 1ns/1ps
`include "flash_prot_consts.svh"
module flash_write_protection_logic #(
    parameter int SECTORS = 128
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Register bus
    input wire flash_prot_pkg::wbReq_t wbReq,
    output flash_prot_pkg::wbRsp_t wbRsp,
    // Hardware or chip-select reset event, one-cycle pulse
    input wire logic deviceResetEvent,
    // Granted program or erase
    output flash_prot_pkg::arrayOp_t arrayOp
);
    localparam int SW = $clog2(SECTORS);

    // ----------------------------------------
    // Elaboration check
    // ----------------------------------------
    generate
        if (SECTORS < `SECTOR_GRAIN || SECTORS > 65536 || (SECTORS & (SECTORS - 1)) != 0) begin
            $error("SECTORS must be a power of two from 64 to 65536");
        end
    endgenerate

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [2:0] regionField, next_regionField;
    logic topBottom, next_topBottom;
    logic permLock, next_permLock;
    logic tempLock, next_tempLock;
    logic smallSplit, next_smallSplit;
    logic smallTopBottom, next_smallTopBottom;
    logic uniHybrid, next_uniHybrid;
    logic writeEnable, next_writeEnable;
    logic [15:0] sectOptions, next_sectOptions;
    logic [63:0] password, next_password;
    logic [SW-1:0] selSector, next_selSector;
    logic [SECTORS-1:0] volBits, next_volBits;
    logic [SECTORS-1:0] nvBits, next_nvBits;
    logic opGranted, next_opGranted;
    logic opRefused, next_opRefused;
    flash_prot_pkg::wbRsp_t next_wbRsp;
    flash_prot_pkg::arrayOp_t next_arrayOp;

    logic take, wr, cfgLocked, persist;
    logic [31:0] wmask;
    logic [SW:0] regionSize;
    logic [SECTORS-1:0] inRegion, effProt;
    logic [SW-1:0] opSector;

    // Decoded access and lock state
    assign take = wbReq.cyc && wbReq.stb && !wbRsp.ack;
    assign wr = take && wbReq.we;
    assign wmask = {{8{wbReq.sel[3]}}, {8{wbReq.sel[2]}}, {8{wbReq.sel[1]}}, {8{wbReq.sel[0]}}};
    assign cfgLocked = permLock || tempLock; // R3 R5
    assign persist = !sectOptions[`OPT_PERSIST]; // R12
    assign opSector = wbReq.dat[SW-1:0];

    // Region size in sectors: SECTORS >> (7 - code), zero for code 0
    always_comb begin
        if (regionField == `REGION_NONE) begin
            regionSize = '0;
        end else begin
            regionSize = (SW + 1)'(SECTORS >> (`REGION_ALL - regionField)); // R2
        end
    end

    // ----------------------------------------
    // Per-sector protection
    // ----------------------------------------
    genvar s;
    generate
        for (s = 0; s < SECTORS; s++) begin : g_sector
            // Top select counts down from the last sector, bottom up from zero
            assign inRegion[s] = topBottom ? ((SW + 1)'(s) < regionSize) // R1 R7
                                           : ((SW + 1)'(s) >= (SW + 1)'(SECTORS) - regionSize);
            // Legacy region or nonvolatile 0 wins; otherwise the volatile bit decides
            assign effProt[s] = inRegion[s] || !nvBits[s] || !volBits[s]; // R9 R10 R13
        end
    endgenerate

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    always_comb begin
        next_regionField = regionField;
        next_topBottom = topBottom;
        next_permLock = permLock;
        next_tempLock = tempLock;
        next_smallSplit = smallSplit;
        next_smallTopBottom = smallTopBottom;
        next_uniHybrid = uniHybrid;
        next_writeEnable = writeEnable;
        next_sectOptions = sectOptions;
        next_password = password;
        next_selSector = selSector;
        next_volBits = volBits;
        next_nvBits = nvBits;
        next_opGranted = opGranted;
        next_opRefused = opRefused;
        next_arrayOp = '0;
        next_wbRsp.ack = take;
        next_wbRsp.dat = '0;
        // Protected writes still spend the write enable, as a flash would
        if (wr) begin
            unique case (wbReq.adr)
                `REG_WREN_CMD: begin
                    next_writeEnable = 1'b1;
                end
                `REG_SECT_SEL: begin
                    next_selSector = (wmask[SW-1:0] & opSector) | (~wmask[SW-1:0] & selSector);
                end
                `REG_STATUS1: begin
                    next_writeEnable = 1'b0;
                    if (writeEnable && !cfgLocked && wmask[`ST1_REGION_LO]) begin // R6
                        next_regionField = wbReq.dat[`ST1_REGION_HI:`ST1_REGION_LO]; // R1
                    end
                end
                `REG_CONFIG1: begin
                    next_writeEnable = 1'b0;
                    if (writeEnable && wmask[0]) begin
                        if (!cfgLocked && !persist) begin // R5 R6 R12
                            next_smallSplit = wbReq.dat[`CF1_SPLIT];
                            next_topBottom = wbReq.dat[`CF1_TOPBOT];
                            next_smallTopBottom = wbReq.dat[`CF1_SMALL_TB];
                        end
                        // Lock bits only ever set from software
                        if (!persist) begin
                            next_permLock = permLock || wbReq.dat[`CF1_PERM]; // R3 R12
                        end
                        next_tempLock = tempLock || wbReq.dat[`CF1_TEMP]; // R3
                    end
                end
                `REG_CONFIG3: begin
                    next_writeEnable = 1'b0;
                    if (writeEnable && !persist && wmask[0]) begin
                        next_uniHybrid = wbReq.dat[`CF3_UNIHYB]; // R12
                    end
                end
                `REG_SECT_OPT: begin
                    next_writeEnable = 1'b0;
                    if (writeEnable && !persist) begin // R12
                        next_sectOptions = (wmask[15:0] & wbReq.dat[15:0])
                                         | (~wmask[15:0] & sectOptions);
                    end
                end
                `REG_PWD_LO: begin
                    next_writeEnable = 1'b0;
                    if (writeEnable && !persist) begin // R12
                        next_password[31:0] = (wmask & wbReq.dat) | (~wmask & password[31:0]);
                    end
                end
                `REG_PWD_HI: begin
                    next_writeEnable = 1'b0;
                    if (writeEnable && !persist) begin // R12
                        next_password[63:32] = (wmask & wbReq.dat) | (~wmask & password[63:32]);
                    end
                end
                `REG_SECT_BITS: begin
                    next_writeEnable = 1'b0;
                    if (writeEnable && wmask[0]) begin
                        next_volBits[selSector] = wbReq.dat[`SB_VOL]; // R11
                        if (!wbReq.dat[`SB_NV]) begin
                            next_nvBits[selSector] = 1'b0; // R11
                        end
                    end
                    // Nonvolatile bits erase only as a whole group
                    if (writeEnable && wmask[`SB_ERASE_ALL] && wbReq.dat[`SB_ERASE_ALL]) begin
                        next_nvBits = '1; // R11
                    end
                end
                `REG_ARRAY_OP: begin
                    next_writeEnable = 1'b0;
                    if (writeEnable && !effProt[opSector]) begin
                        next_arrayOp.valid = 1'b1;
                        next_arrayOp.erase = wbReq.dat[`OP_ERASE];
                        next_arrayOp.sector = 16'(opSector);
                        next_opGranted = 1'b1;
                        next_opRefused = 1'b0;
                    end else begin
                        next_opGranted = 1'b0;
                        next_opRefused = 1'b1; // R14
                    end
                end
                default: begin
                end
            endcase
        end
        // Read data; unmapped offsets answer zero
        if (take && !wbReq.we) begin
            unique case (wbReq.adr)
                `REG_STATUS1: begin
                    next_wbRsp.dat[`ST1_REGION_HI:`ST1_REGION_LO] = regionField;
                    next_wbRsp.dat[`ST1_WEL] = writeEnable;
                end
                `REG_CONFIG1: begin
                    next_wbRsp.dat[`CF1_SPLIT] = smallSplit;
                    next_wbRsp.dat[`CF1_TOPBOT] = topBottom;
                    next_wbRsp.dat[`CF1_PERM] = permLock;
                    next_wbRsp.dat[`CF1_SMALL_TB] = smallTopBottom;
                    next_wbRsp.dat[`CF1_TEMP] = tempLock;
                end
                `REG_CONFIG3: next_wbRsp.dat[`CF3_UNIHYB] = uniHybrid;
                `REG_SECT_OPT: next_wbRsp.dat[15:0] = sectOptions;
                `REG_PWD_LO: next_wbRsp.dat = password[31:0];
                `REG_PWD_HI: next_wbRsp.dat = password[63:32];
                `REG_SECT_SEL: next_wbRsp.dat[SW-1:0] = selSector;
                `REG_SECT_BITS: begin
                    next_wbRsp.dat[`SB_VOL] = volBits[selSector];
                    next_wbRsp.dat[`SB_NV] = nvBits[selSector];
                    next_wbRsp.dat[`SB_PROT] = effProt[selSector];
                end
                `REG_ARRAY_STAT: begin
                    next_wbRsp.dat[`AST_GRANT] = opGranted;
                    next_wbRsp.dat[`AST_REFUSED] = opRefused;
                end
                default: begin
                end
            endcase
        end
        // Device reset drops volatile state; it outranks a same-cycle write
        if (deviceResetEvent) begin
            next_tempLock = 1'b0; // R4
            next_writeEnable = 1'b0;
            next_volBits = '1;
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (reset) begin
            regionField <= `REGION_NONE;
            topBottom <= 1'b0;
            permLock <= 1'b0;
            tempLock <= 1'b0;
            smallSplit <= 1'b0;
            smallTopBottom <= 1'b0;
            uniHybrid <= 1'b0;
            writeEnable <= 1'b0;
            sectOptions <= `SECT_OPT_RESET;
            password <= `PWD_RESET;
            selSector <= '0;
            volBits <= '1;
            nvBits <= '1;
            opGranted <= 1'b0;
            opRefused <= 1'b0;
            wbRsp <= '0;
            arrayOp <= '0;
        end else begin
            regionField <= next_regionField;
            topBottom <= next_topBottom;
            permLock <= next_permLock;
            tempLock <= next_tempLock;
            smallSplit <= next_smallSplit;
            smallTopBottom <= next_smallTopBottom;
            uniHybrid <= next_uniHybrid;
            writeEnable <= next_writeEnable;
            sectOptions <= next_sectOptions;
            password <= next_password;
            selSector <= next_selSector;
            volBits <= next_volBits;
            nvBits <= next_nvBits;
            opGranted <= next_opGranted;
            opRefused <= next_opRefused;
            wbRsp <= next_wbRsp;
            arrayOp <= next_arrayOp;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    ack_single_pulse_a: assert property (wbRsp.ack |=> !wbRsp.ack) // R8
        else $error("ack held longer than one cycle");
    ack_after_request_a: assert property (take |=> wbRsp.ack) // R8
        else $error("request not acknowledged next cycle");
    locked_region_stable_a: assert property (cfgLocked // R5
        |=> $stable(regionField) && $stable(topBottom))
        else $error("region changed while locked");
    perm_lock_sticky_a: assert property (permLock |=> permLock [*8]) // R3
        else $error("permanent lock released");
    temp_lock_release_a: assert property (deviceResetEvent |=> !tempLock) // R4
        else $error("temporary lock survived reset event");
    persist_freeze_a: assert property (persist // R12
        |=> $stable(sectOptions) && $stable(password) && $stable(uniHybrid))
        else $error("persistent field changed");
    refused_op_a: assert property (wr && wbReq.adr == `REG_ARRAY_OP && effProt[opSector] // R14
        |=> !arrayOp.valid && opRefused)
        else $error("protected sector operation granted");
    nv_over_vol_a: assert property (!nvBits[selSector] |-> effProt[selSector]) // R13
        else $error("nonvolatile protection bypassed");
    open_write_a: assert property (wr && writeEnable && !cfgLocked // R6
        && wbReq.adr == `REG_STATUS1 && wbReq.sel[0]
        |=> regionField == $past(wbReq.dat[`ST1_REGION_HI:`ST1_REGION_LO]))
        else $error("unlocked region write lost");
    full_region_a: assert property (regionField == `REGION_ALL |-> &inRegion) // R2
        else $error("all-sector code leaves a sector open");

    grant_seen_c: cover property (arrayOp.valid);
    refusal_seen_c: cover property (opRefused && cfgLocked);
    temp_released_c: cover property (tempLock ##1 !tempLock);
endmodule

// ---- verif/host_flash_ctrl_model.sv ----
// Host flash controller model issuing register transactions.
// Assumes the protection block's Wishbone slave on one clock.
`timescale 1ns/1ps
`include "flash_prot_consts.svh"
module host_flash_ctrl_model (
    // Clock
    input wire logic core_clk,
    // Register bus
    output flash_prot_pkg::wbReq_t wbReq,
    input wire flash_prot_pkg::wbRsp_t wbRsp
);
    // ----------------------------------------
    // Bus cycles
    // ----------------------------------------
    initial wbReq = '0;

    // One classic cycle; released lines show inverted values, not stale ones
    task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                       input logic [3:0] sel, output logic [31:0] rdat, output logic ok);
        int n;
        ok = 1'b0;
        rdat = 32'h0;
        @(posedge core_clk);
        wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sel, dat: dat};
        for (n = 0; n < 16 && ok == 1'b0; n++) begin
            @(posedge core_clk);
            if (wbRsp.ack === 1'b1) begin
                ok = 1'b1;
                rdat = wbRsp.dat;
            end
        end
        wbReq <= '{cyc: 1'b0, stb: 1'b0, we: 1'b0, adr: ~adr, sel: 4'h0, dat: ~dat};
    endtask

    // Write enable transaction always precedes the guarded write
    task automatic protected_write(input logic [7:0] adr, input logic [31:0] dat,
                                   input logic [3:0] sel, output logic ok);
        logic [31:0] d;
        logic okEn;
        bus(1'b1, `REG_WREN_CMD, 32'h0, 4'hF, d, okEn);
        bus(1'b1, adr, dat, sel, d, ok);
        ok = ok & okEn;
    endtask
endmodule

// ---- verif/flash_write_protection_logic_bench.sv ----
// Self-checking bench for the write-protection block.
// Assumes the host model drives the bus and the bench drives resets.
`timescale 1ns/1ps
`include "flash_prot_consts.svh"
module flash_write_protection_logic_bench;
    localparam int SECTORS = 128;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic deviceResetEvent = 1'b0;
    flash_prot_pkg::wbReq_t wbReq;
    flash_prot_pkg::wbRsp_t wbRsp;
    flash_prot_pkg::arrayOp_t arrayOp;
    flash_prot_pkg::arrayOp_t lastOp = '0;
    int opCount = 0;
    int err_total = 0;
    int comparisons = 0;

    // ----------------------------------------
    // Clock, partner and design
    // ----------------------------------------
    always #2.5 core_clk = ~core_clk;

    host_flash_ctrl_model i_host (.core_clk(core_clk), .wbReq(wbReq), .wbRsp(wbRsp));

    flash_write_protection_logic #(.SECTORS(SECTORS)) i_dut (
        .core_clk(core_clk), .reset(reset), .wbReq(wbReq), .wbRsp(wbRsp),
        .deviceResetEvent(deviceResetEvent), .arrayOp(arrayOp));

    // Granted operations are counted, the last one kept for its fields
    always @(posedge core_clk) begin
        if (arrayOp.valid === 1'b1) begin
            opCount++;
            lastOp = arrayOp;
        end
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic report_and_stop;
        if (err_total == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // A bus cycle that never got its ack ends the run
    task automatic alive(input logic ok);
        check({31'h0, ok}, 32'h1);
        if (ok !== 1'b1) report_and_stop();
    endtask

    task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] d;
        logic ok;
        i_host.bus(1'b0, adr, 32'h0, 4'hF, d, ok);
        alive(ok);
        check(d, exp);
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        logic ok;
        i_host.protected_write(adr, dat, 4'hF, ok);
        alive(ok);
    endtask

    // Write without a preceding write enable
    task automatic raw(input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel);
        logic [31:0] d;
        logic ok;
        i_host.bus(1'b1, adr, dat, sel, d, ok);
        alive(ok);
    endtask

    task automatic pulse_dev_reset;
        @(posedge core_clk);
        deviceResetEvent <= 1'b1;
        @(posedge core_clk);
        deviceResetEvent <= 1'b0;
    endtask

    task automatic try_op(input int sector, input logic erase, input logic grant,
                          input logic en);
        int c;
        c = opCount;
        if (en) wr(`REG_ARRAY_OP, {15'h0, erase, 16'(sector)});
        else raw(`REG_ARRAY_OP, {15'h0, erase, 16'(sector)}, 4'hF);
        @(posedge core_clk);
        check(32'(opCount - c), {31'h0, grant});
        if (grant) check({15'h0, lastOp.erase, lastOp.sector}, {15'h0, erase, 16'(sector)});
        rd(`REG_ARRAY_STAT, {30'h0, ~grant, grant});
    endtask

    function automatic logic in_region(input int s, input int code, input int tb);
        int size;
        size = (code == 0) ? 0 : (SECTORS >> (7 - code));
        return (tb != 0) ? (s < size) : (s >= SECTORS - size);
    endfunction

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        int size;
        int s;
        int p[4];
        repeat (12) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        rd(`REG_STATUS1, 32'h0);
        rd(`REG_CONFIG1, 32'h0);
        rd(`REG_SECT_OPT, 32'h0000_FFFF);
        rd(`REG_PWD_HI, 32'hFFFF_FFFF);
        rd(8'h3C, 32'h0);
        // Every region code from both ends, probing each boundary
        for (int tb = 0; tb < 2; tb++) begin
            for (int code = 0; code < 8; code++) begin
                wr(`REG_CONFIG1, 32'(tb << 5));
                wr(`REG_STATUS1, 32'(code << 2));
                rd(`REG_STATUS1, 32'(code << 2));
                size = (code == 0) ? 0 : (SECTORS >> (7 - code));
                p = '{SECTORS - size, SECTORS - size - 1, size, size - 1};
                foreach (p[i]) begin
                    s = p[i] & (SECTORS - 1);
                    try_op(s, tb[0], ~in_region(s, code, tb), 1'b1);
                end
            end
        end
        // Temporary lock holds region and select until device reset
        wr(`REG_CONFIG1, 32'h0);
        wr(`REG_STATUS1, 32'hC);
        wr(`REG_CONFIG1, 32'h1);
        rd(`REG_CONFIG1, 32'h1);
        wr(`REG_STATUS1, 32'h0);
        rd(`REG_STATUS1, 32'hC);
        wr(`REG_CONFIG1, 32'h21);
        rd(`REG_CONFIG1, 32'h1);
        try_op(120, 1'b0, 1'b0, 1'b1);
        pulse_dev_reset();
        rd(`REG_CONFIG1, 32'h0);
        wr(`REG_STATUS1, 32'h0);
        rd(`REG_STATUS1, 32'h0);
        try_op(120, 1'b0, 1'b1, 1'b1);
        // Permanent lock survives a device reset
        wr(`REG_STATUS1, 32'h1C);
        wr(`REG_CONFIG1, 32'h10);
        rd(`REG_CONFIG1, 32'h10);
        wr(`REG_CONFIG1, 32'h74);
        rd(`REG_CONFIG1, 32'h10);
        pulse_dev_reset();
        wr(`REG_STATUS1, 32'h0);
        rd(`REG_STATUS1, 32'h1C);
        try_op(0, 1'b1, 1'b0, 1'b1);
        @(posedge core_clk);
        reset <= 1'b1;
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        rd(`REG_CONFIG1, 32'h0);
        rd(`REG_STATUS1, 32'h0);
        // Per-sector bits, sector select needs no write enable
        raw(`REG_SECT_SEL, 32'h5, 4'hF);
        wr(`REG_SECT_BITS, 32'h2);
        rd(`REG_SECT_BITS, 32'h6);
        try_op(5, 1'b0, 1'b0, 1'b1);
        try_op(6, 1'b0, 1'b1, 1'b1);
        wr(`REG_SECT_BITS, 32'h3);
        rd(`REG_SECT_BITS, 32'h3);
        try_op(5, 1'b1, 1'b1, 1'b1);
        wr(`REG_SECT_BITS, 32'h1);
        rd(`REG_SECT_BITS, 32'h5);
        try_op(5, 1'b0, 1'b0, 1'b1);
        wr(`REG_SECT_BITS, 32'h2);
        pulse_dev_reset();
        rd(`REG_SECT_BITS, 32'h5);
        wr(`REG_SECT_BITS, 32'h103);
        rd(`REG_SECT_BITS, 32'h3);
        try_op(5, 1'b0, 1'b0, 1'b0);
        // Persistent scheme freezes the listed fields
        wr(`REG_SECT_OPT, 32'hFFFD);
        rd(`REG_SECT_OPT, 32'hFFFD);
        wr(`REG_CONFIG1, 32'h74);
        rd(`REG_CONFIG1, 32'h0);
        wr(`REG_CONFIG3, 32'h8);
        rd(`REG_CONFIG3, 32'h0);
        wr(`REG_SECT_OPT, 32'hFFFF);
        rd(`REG_SECT_OPT, 32'hFFFD);
        wr(`REG_PWD_LO, 32'h0);
        rd(`REG_PWD_LO, 32'hFFFF_FFFF);
        report_and_stop();
    end

    // Watchdog on the whole run
    initial begin
        repeat (60000) @(posedge core_clk);
        err_total++;
        report_and_stop();
    end
endmodule
